// ==== hw/io_expander_defs.svh ====
// Constants for the serial command port of the ten-port I/O expander.
// How it works
// - Frame with D15 low is a write of data to the addressed register.
// - Other bit counts keep the newest sixteen bits, older frames included.
// - Chip select rising latches the last sixteen bits, oldest as D15.
// - Frame with D15 high is a read; D14 to D8 carry the address.
// - Low eight bits of a read frame are dummy and ignored.
// - After a read, the register value fills shift positions D7 to D0.
// - Read data appears as the second byte out during the next frame.
// - Input bits emerge 15.5 clocks later, changing on falling clock edges.
// - Level zero drives a port low; other values release it high.
// - A write to address 0x0A sets all ten port levels at once.
// - Address 0x0E reads inputs of ports 7 to 0; 0x0F reads ports 9, 8 low.
`ifndef IO_EXPANDER_DEFS_SVH
`define IO_EXPANDER_DEFS_SVH

`define FRAME_BITS       16
`define RW_BIT           15
`define ADDR_HI          14
`define ADDR_LO          8
`define DATA_HI          7
`define ADDR_W           7
`define LEVEL_W          8
`define NUM_PORTS        10
`define MID_FIRST        4
`define HIGH_FIRST       8
`define ADDR_LAST_PORT   7'h09
`define ADDR_ALL_PORTS   7'h0A
`define ADDR_PORTS_LOW   7'h0B
`define ADDR_PORTS_MID   7'h0C
`define ADDR_PORTS_HIGH  7'h0D
`define ADDR_INPUTS_LOW  7'h0E
`define ADDR_INPUTS_HIGH 7'h0F
`define LEVEL_RESET      8'hFF
`define LEVEL_LOW        8'h00
`define READ_NONE        8'h00
`define INPUTS_PAD       6'h00

`endif

// ==== hw/io_expander_pkg.sv ====
// Types shared by the serial command port and its port bank.
`include "io_expander_defs.svh"
package io_expander_pkg;
   typedef logic [`LEVEL_W-1:0]                  level_type;
   typedef logic [`NUM_PORTS-1:0][`LEVEL_W-1:0] level_array_type;
   typedef logic [`ADDR_W-1:0]                   addr_type;
   typedef logic [`FRAME_BITS-1:0]               frame_type;
   typedef enum logic [0:0] {st_wait, st_execute} cmd_state_type;
endpackage

// ==== hw/io_expander_serial_port.sv ====
// Sixteen-bit serial command port of the ten-port I/O expander.
`timescale 1ns/1ns
`include "io_expander_defs.svh"
module io_expander_serial_port (
   input  wire logic                  clk_in,                    // System clock.
   input  wire logic                  arst_n_in,                 // Async reset, low.
   input  wire logic                  ce_in,                     // Clock enable.
   input  wire logic                  sclk_in,                   // Serial clock.
   input  wire logic                  cs_n_in,                   // Chip select, low.
   input  wire logic                  serial_data_in,            // Serial data in.
   input  wire logic [`NUM_PORTS-1:0] io_port_in,                // Port pin levels.
   output logic                       serial_out_or_osc_pin_out, // Serial data out.
   output logic [`NUM_PORTS-1:0]      io_port_out,               // Port drive value.
   output logic [`NUM_PORTS-1:0]      io_port_oe_out             // Port drive enable.
);
   import io_expander_pkg::*;

   // Serial clock domain.
   frame_type     shift;
   frame_type     next_shift;
   frame_type     overlay;
   logic          frame_active;
   logic          frame_rst_n;
   logic          next_dout;

   // System clock domain.
   logic          cs_s1, cs_s2, cs_s3;
   logic          cs_level, next_cs_level;
   logic          cs_rise;
   cmd_state_type state, next_state;
   frame_type     frame, next_frame;
   logic          wr_stb, next_wr_stb;
   addr_type      wr_addr, next_wr_addr;
   level_type     wr_data, next_wr_data;
   logic          read_valid, next_read_valid;
   level_type     read_byte, next_read_byte;
   level_array_type         levels;
   logic [`NUM_PORTS-1:0]   inputs;

   function automatic level_type read_lookup(input addr_type addr,
                                             input level_array_type lv,
                                             input logic [`NUM_PORTS-1:0] pins);
      level_type value;
      value = `READ_NONE;
      if (addr <= `ADDR_LAST_PORT) begin
         value = lv[addr];
      end else begin
         case (addr)
            `ADDR_ALL_PORTS,
            `ADDR_PORTS_LOW:   value = lv[0];
            `ADDR_PORTS_MID:   value = lv[`MID_FIRST];
            `ADDR_PORTS_HIGH:  value = lv[`HIGH_FIRST];
            `ADDR_INPUTS_LOW:  value = pins[`HIGH_FIRST-1:0];
            `ADDR_INPUTS_HIGH: value = {`INPUTS_PAD, pins[`NUM_PORTS-1:`HIGH_FIRST]};
            default:           value = `READ_NONE;
         endcase
      end
      return value;
   endfunction

   // ---------------- Serial clock domain ----------------

   // The read byte and its valid flag are held steady by the system domain from
   // shortly after a frame ends until the next one ends, so the first rising edge
   // of a frame may sample them without a synchroniser.
   always_comb begin
      overlay = shift;
      if (!frame_active && read_valid) begin
         overlay[`DATA_HI:0] = read_byte;
      end
      next_shift = shift;
      if (!cs_n_in) begin
         next_shift = {overlay[`FRAME_BITS-2:0], serial_data_in};
      end
      next_dout = shift[`RW_BIT];
   end

   always_ff @(posedge sclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         shift <= '0;
      end else begin
         shift <= next_shift;
      end
   end

   // Chip select high clears this flag without any clock edge, because the
   // serial clock may stand still between frames.
   assign frame_rst_n = arst_n_in & ~cs_n_in;

   always_ff @(posedge sclk_in or negedge frame_rst_n) begin
      if (!frame_rst_n) begin
         frame_active <= 1'b0;
      end else begin
         frame_active <= 1'b1;
      end
   end

   always_ff @(negedge sclk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         serial_out_or_osc_pin_out <= 1'b0;
      end else begin
         serial_out_or_osc_pin_out <= next_dout;
      end
   end

   shift_in_a: assert property (@(posedge sclk_in) disable iff (!arst_n_in)
      !cs_n_in |=> shift[0] == $past(serial_data_in))
      else $error("selected rising edge did not shift in the input bit");

   shift_hold_a: assert property (@(posedge sclk_in) disable iff (!arst_n_in)
      cs_n_in |=> shift == $past(shift))
      else $error("shift register moved while chip select was high");

   dout_step_a: assert property (@(negedge sclk_in) disable iff (!arst_n_in)
      !cs_n_in ##1 !cs_n_in |-> serial_out_or_osc_pin_out == $past(shift[`RW_BIT - 1], 2))
      else $error("serial output did not follow the shift register");

   read_load_a: assert property (@(posedge sclk_in) disable iff (!arst_n_in)
      !cs_n_in && !frame_active && read_valid
      |=> shift[`DATA_HI+1:1] == $past(read_byte))
      else $error("read data was not loaded at the start of the frame");

   // ---------------- System clock domain ----------------

   // A chip select change counts once the second and third stages agree.
   always_comb begin
      cs_rise       = !cs_level && cs_s2 && cs_s3;
      next_cs_level = cs_level;
      if (cs_s2 == cs_s3) begin
         next_cs_level = cs_s2;
      end
   end

   always_comb begin
      next_state      = state;
      next_frame      = frame;
      next_wr_stb     = 1'b0;
      next_wr_addr    = wr_addr;
      next_wr_data    = wr_data;
      next_read_valid = read_valid;
      next_read_byte  = read_byte;
      case (state)
         st_wait: begin
            if (cs_rise) begin
               next_frame = shift;
               next_state = st_execute;
            end
         end
         st_execute: begin
            next_state = st_wait;
            if (frame[`RW_BIT]) begin
               next_read_valid = 1'b1;
               next_read_byte  = read_lookup(frame[`ADDR_HI:`ADDR_LO], levels, inputs);
            end else begin
               next_read_valid = 1'b0;
               next_wr_stb     = 1'b1;
               next_wr_addr    = frame[`ADDR_HI:`ADDR_LO];
               next_wr_data    = frame[`DATA_HI:0];
            end
         end
         default: begin
            next_state = st_wait;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cs_s1      <= 1'b1;
         cs_s2      <= 1'b1;
         cs_s3      <= 1'b1;
         cs_level   <= 1'b1;
         state      <= st_wait;
         frame      <= '0;
         wr_stb     <= 1'b0;
         wr_addr    <= '0;
         wr_data    <= '0;
         read_valid <= 1'b0;
         read_byte  <= `READ_NONE;
      end else if (ce_in) begin
         cs_s1      <= cs_n_in;
         cs_s2      <= cs_s1;
         cs_s3      <= cs_s2;
         cs_level   <= next_cs_level;
         state      <= next_state;
         frame      <= next_frame;
         wr_stb     <= next_wr_stb;
         wr_addr    <= next_wr_addr;
         wr_data    <= next_wr_data;
         read_valid <= next_read_valid;
         read_byte  <= next_read_byte;
      end
   end

   port_bank #(
      .NUM_PORTS (`NUM_PORTS)
   ) u_port_bank (
      .clk_in         (clk_in),
      .arst_n_in      (arst_n_in),
      .ce_in          (ce_in),
      .wr_stb_in      (wr_stb),
      .wr_addr_in     (wr_addr),
      .wr_data_in     (wr_data),
      .io_port_in     (io_port_in),
      .io_port_out    (io_port_out),
      .io_port_oe_out (io_port_oe_out),
      .levels_out     (levels),
      .inputs_out     (inputs)
   );

   latch_frame_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      state == st_wait && cs_rise && ce_in |=> frame == $past(shift) && state == st_execute)
      else $error("completed frame was not latched on chip select rise");

   write_cmd_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      state == st_execute && ce_in && !frame[`RW_BIT]
      |=> wr_stb && wr_addr == $past(frame[`ADDR_HI:`ADDR_LO])
          && wr_data == $past(frame[`DATA_HI:0]))
      else $error("write frame did not produce its write strobe");

   read_cmd_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      state == st_execute && ce_in && frame[`RW_BIT] |=> !wr_stb && read_valid)
      else $error("read frame disturbed the port levels");

   one_strobe_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      wr_stb && ce_in |=> !wr_stb)
      else $error("write strobe lasted more than one enabled cycle");

   inputs_low_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      state == st_execute && ce_in && frame[`RW_BIT]
      && frame[`ADDR_HI:`ADDR_LO] == `ADDR_INPUTS_LOW
      |=> read_byte == $past(inputs[`HIGH_FIRST-1:0]))
      else $error("input read of the low ports returned wrong data");

   inputs_high_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      state == st_execute && ce_in && frame[`RW_BIT]
      && frame[`ADDR_HI:`ADDR_LO] == `ADDR_INPUTS_HIGH
      |=> read_byte[`DATA_HI:`NUM_PORTS-`HIGH_FIRST] == `INPUTS_PAD
          && read_byte[`NUM_PORTS-`HIGH_FIRST-1:0] == $past(inputs[`NUM_PORTS-1:`HIGH_FIRST]))
      else $error("input read of the high ports returned wrong data");

endmodule // io_expander_serial_port

// ==== hw/port_bank.sv ====
// Output level registers, open-drain pin drive and input synchronisers.
`timescale 1ns/1ns
`include "io_expander_defs.svh"
module port_bank #(
   parameter int NUM_PORTS = `NUM_PORTS
) (
   input  wire logic                             clk_in,         // System clock.
   input  wire logic                             arst_n_in,      // Async reset, low.
   input  wire logic                             ce_in,          // Clock enable.
   input  wire logic                             wr_stb_in,      // Write strobe.
   input  wire io_expander_pkg::addr_type        wr_addr_in,     // Write address.
   input  wire io_expander_pkg::level_type       wr_data_in,     // Write data.
   input  wire logic [NUM_PORTS-1:0]             io_port_in,     // Pin levels.
   output logic [NUM_PORTS-1:0]                  io_port_out,    // Pin drive value.
   output logic [NUM_PORTS-1:0]                  io_port_oe_out, // Pin drive enable.
   output io_expander_pkg::level_array_type      levels_out,     // Level registers.
   output logic [NUM_PORTS-1:0]                  inputs_out      // Filtered inputs.
);
   import io_expander_pkg::*;

   if (NUM_PORTS != `NUM_PORTS) begin : g_bad_ports
      $error("port_bank serves exactly the documented port count");
   end

   function automatic logic hits_port(input addr_type addr, input int idx);
      logic hit;
      hit = (addr == addr_type'(idx)) || (addr == `ADDR_ALL_PORTS);
      hit = hit || (addr == `ADDR_PORTS_LOW && idx < `MID_FIRST);
      hit = hit || (addr == `ADDR_PORTS_MID && idx >= `MID_FIRST && idx < `HIGH_FIRST);
      hit = hit || (addr == `ADDR_PORTS_HIGH && idx >= `HIGH_FIRST);
      return hit;
   endfunction

   level_array_type      next_levels;
   logic [NUM_PORTS-1:0] next_oe;
   logic [NUM_PORTS-1:0] sync1, sync2, sync3;
   logic [NUM_PORTS-1:0] next_inputs;

   for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
      always_comb begin
         next_levels[i] = levels_out[i];
         if (wr_stb_in && hits_port(wr_addr_in, i)) begin
            next_levels[i] = wr_data_in;
         end
         next_oe[i] = (next_levels[i] == `LEVEL_LOW);
      end

      drive_low_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
         io_port_oe_out[i] == (levels_out[i] == `LEVEL_LOW))
         else $error("port drive enable disagrees with its level register");
   end

   // A pin change counts only once the second and third stages agree.
   always_comb begin
      next_inputs = (sync2 & ~(sync2 ^ sync3)) | (inputs_out & (sync2 ^ sync3));
   end

   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         levels_out     <= {`NUM_PORTS{`LEVEL_RESET}};
         io_port_oe_out <= '0;
         io_port_out    <= '0;
         sync1          <= '0;
         sync2          <= '0;
         sync3          <= '0;
         inputs_out     <= '0;
      end else if (ce_in) begin
         levels_out     <= next_levels;
         io_port_oe_out <= next_oe;
         io_port_out    <= '0;
         sync1          <= io_port_in;
         sync2          <= sync1;
         sync3          <= sync2;
         inputs_out     <= next_inputs;
      end
   end

   write_all_a: assert property (@(posedge clk_in) disable iff (!arst_n_in)
      wr_stb_in && ce_in && wr_addr_in == `ADDR_ALL_PORTS
      |=> levels_out == {`NUM_PORTS{$past(wr_data_in)}})
      else $error("broadcast write did not reach every port");

endmodule // port_bank

// ==== test/io_expander_serial_port_bench.sv ====
// Self-checking bench for the serial command port of the I/O expander.
`timescale 1ns/1ns
`include "io_expander_defs.svh"
module io_expander_serial_port_bench;
   import io_expander_pkg::*;
   logic                  clk_in;
   logic                  arst_n_in;
   logic                  ce_in;
   wire logic             sclk;
   wire logic             cs_n;
   wire logic             mosi;
   wire logic             dout;
   wire logic [`NUM_PORTS-1:0] drive_value;
   wire logic [`NUM_PORTS-1:0] drive_enable;
   wire logic [`NUM_PORTS-1:0] pin_level;
   logic [`NUM_PORTS-1:0] ext_low;
   logic [15:0]           rx;
   int                    fail_count;
   int                    num_checks;

   // Pulled-up wires: either the device or the outside world may sink them.
   assign pin_level = ((drive_enable & drive_value) | ~drive_enable) & ~ext_low;

   io_expander_serial_port dut (
      .clk_in                    (clk_in),
      .arst_n_in                 (arst_n_in),
      .ce_in                     (ce_in),
      .sclk_in                   (sclk),
      .cs_n_in                   (cs_n),
      .serial_data_in            (mosi),
      .io_port_in                (pin_level),
      .serial_out_or_osc_pin_out (dout),
      .io_port_out               (drive_value),
      .io_port_oe_out            (drive_enable)
   );

   spi_master_model m (
      .sclk_out (sclk),
      .cs_n_out (cs_n),
      .mosi_out (mosi),
      .miso_in  (dout)
   );

   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end

   task automatic conclude();
      if (fail_count == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] expected);
      num_checks++;
      if (seen !== expected) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, expected);
      end
   endtask

   // Execution lands a few system cycles after deselect, so poll with a bound.
   task automatic wait_oe(input logic [`NUM_PORTS-1:0] expected);
      for (int i = 0; i < 30; i++) begin
         @(negedge clk_in);
         if (drive_enable === expected) begin
            break;
         end
      end
      check(16'(drive_enable), 16'(expected));
      if (drive_enable !== expected) begin
         conclude();
      end
   endtask

   task automatic gap();
      repeat (10) @(negedge clk_in);
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      m.xfer({16'h0000, 1'b0, a, d}, 16, 1'b0, rx);
      gap();
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] expected);
      m.xfer({16'h0000, 1'b1, a, 8'hA5}, 16, 1'b0, rx);
      gap();
      m.xfer({16'h0000, 1'b0, 7'h10, 8'h00}, 16, 1'b0, rx);
      gap();
      check(rx, {1'b1, a, expected});
   endtask

   task automatic t_reset();
      check(16'(drive_enable), 16'h0000);
      check(16'(drive_value), 16'h0000);
      rd(7'h00, 8'hFF);
   endtask

   task automatic t_write_read();
      wr(7'h03, 8'h00);
      wait_oe(10'h008);
      rd(7'h03, 8'h00);
      rd(7'h04, 8'hFF);
   endtask

   task automatic t_group();
      wr(7'h0B, 8'h00);
      wait_oe(10'h00F);
      wr(7'h0C, 8'h00);
      wait_oe(10'h0FF);
      rd(7'h0D, 8'hFF);
      rd(7'h0C, 8'h00);
      wr(7'h0D, 8'h00);
      wait_oe(10'h3FF);
      wr(7'h0A, 8'h01);
      wait_oe(10'h000);
      rd(7'h0A, 8'h01);
      rd(7'h0B, 8'h01);
      rd(7'h20, 8'h00);
      wr(7'h0A, 8'h00);
      wait_oe(10'h3FF);
      wr(7'h0A, 8'h01);
      wait_oe(10'h000);
   endtask

   task automatic t_inputs();
      ext_low = 10'h2A5;
      gap();
      rd(7'h0E, 8'h5A);
      rd(7'h0F, 8'h01);
      ext_low = 10'h000;
   endtask

   // Extra leading bits must fall off the top of the shift register.
   task automatic t_long();
      m.xfer({8'h00, 8'hC3, 1'b0, 7'h05, 8'h00}, 24, 1'b0, rx);
      gap();
      wait_oe(10'h020);
      // Two short frames: the second keeps the first one's byte as its top half.
      m.xfer({24'h000000, 8'h07}, 8, 1'b0, rx);
      gap();
      m.xfer(32'h00000000, 8, 1'b0, rx);
      gap();
      wait_oe(10'h0A0);
   endtask

   task automatic t_echo();
      m.xfer({16'h0000, 16'h0600}, 16, 1'b1, rx);
      gap();
      wait_oe(10'h0E0);
      m.idle_clocks(5);
      gap();
      m.xfer({16'h0000, 1'b0, 7'h10, 8'h00}, 16, 1'b0, rx);
      gap();
      check(rx, 16'h0600);
      check(16'(drive_enable), 16'h00E0);
   endtask

   // A low clock enable freezes the command side, so a frame sent then is never executed.
   task automatic t_freeze();
      ce_in = 1'b0;
      m.xfer({16'h0000, 16'h0800}, 16, 1'b0, rx);
      gap();
      gap();
      check(16'(drive_enable), 16'h00E0);
      ce_in = 1'b1;
      gap();
      check(16'(drive_enable), 16'h00E0);
      wr(7'h09, 8'h00);
      wait_oe(10'h2E0);
   endtask

   initial begin
      fail_count = 0;
      num_checks = 0;
      ce_in = 1'b1;
      ext_low = 10'h000;
      arst_n_in = 1'b0;
      repeat (5) @(negedge clk_in);
      arst_n_in = 1'b1;
      gap();
      t_reset();
      t_write_read();
      t_group();
      t_inputs();
      t_long();
      t_echo();
      t_freeze();
      conclude();
   end
endmodule // io_expander_serial_port_bench

// ==== test/spi_master_model.sv ====
// Serial command master model that drives the expander's link pins.
`timescale 1ns/1ns
module spi_master_model (
   output logic      sclk_out, // Serial clock, idle low.
   output logic      cs_n_out, // Chip select, low.
   output logic      mosi_out, // Serial data to the device.
   input  wire logic miso_in   // Serial data from the device.
);
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b1;
   end

   // The clock runs at a 48 ns period, inside a frame and in idle_clocks with chip select high.
   // One device only: its output returns to the master, no chain.
   task automatic xfer(input logic [31:0] tx, input int n, input bit hi_end,
                       output logic [15:0] rx);
      rx = 16'h0000;
      cs_n_out = 1'b0;
      #12;
      for (int i = n - 1; i >= 0; i--) begin
         mosi_out = tx[i];
         #12 sclk_out = 1'b1;
         // The device moves its output on falling edges, so it is settled here.
         rx = {rx[14:0], miso_in};
         #24;
         if (i > 0 || !hi_end) begin
            sclk_out = 1'b0;
            #12;
         end
      end
      // Deselect with clock high or low.
      cs_n_out = 1'b1;
      #12 sclk_out = 1'b0;
      // Released data line shows the inverse so a stale level is never trusted.
      mosi_out = ~mosi_out;
   endtask

   task automatic idle_clocks(input int k);
      for (int i = 0; i < k; i++) begin
         mosi_out = i[0];
         #24 sclk_out = 1'b1;
         #24 sclk_out = 1'b0;
      end
   endtask
endmodule // spi_master_model
